// ---- verilog/hbs_host_agent.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbs_host_agent #(
    parameter bit COMPAT_BRIDGE = 1'b1
) (
    // clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    // request lines
    input  wire logic                           addr_strobe_n_in,
    output logic                                addr_strobe_n_out,
    output logic                                addr_strobe_oe,
    input  wire logic [hbs_pkg::REQ_W-1:0]      req_type_n_in,
    output logic      [hbs_pkg::REQ_W-1:0]      req_type_n_out,
    output logic                                req_type_oe,
    input  wire logic                           cmd_parity_n_in,
    output logic                                cmd_parity_n_out,
    output logic                                cmd_parity_oe,
    input  wire logic [hbs_pkg::BE_W-1:0]       byte_en_n_in,
    input  wire logic                           sysmgmt_space_n_in,
    // data lines
    input  wire logic [hbs_pkg::DATA_W-1:0]     data_n_in,
    output logic      [hbs_pkg::DATA_W-1:0]     data_n_out,
    input  wire logic [hbs_pkg::ECC_W-1:0]      data_ecc_n_in,
    output logic      [hbs_pkg::ECC_W-1:0]      data_ecc_n_out,
    output logic                                data_oe,
    input  wire logic                           data_valid_n_in,
    output logic                                data_valid_n_out,
    output logic                                data_hold_n_out,
    input  wire logic                           target_ready_n_in,
    output logic                                target_ready_n_out,
    output logic                                target_ready_oe,
    // response, snoop and lock lines
    output logic                                defer_n_out,
    output logic                                defer_oe,
    input  wire logic [hbs_pkg::RESP_W-1:0]     response_code_n_in,
    output logic      [hbs_pkg::RESP_W-1:0]     response_code_n_out,
    input  wire logic                           resp_parity_n_in,
    output logic                                resp_parity_n_out,
    output logic                                resp_oe,
    output logic                                snoop_hit_n_out,
    output logic                                snoop_modified_n_out,
    output logic                                snoop_oe,
    output logic                                lock_n_out,
    output logic                                lock_oe,
    // sideband outputs
    output logic                                cache_drain_n,
    output logic                                sysmgmt_ack_n,
    // user request side
    input  wire logic                           req_go,
    input  wire logic [hbs_pkg::REQ_W-1:0]      req_cmd,
    input  wire logic [hbs_pkg::REQ_W-1:0]      req_len,
    input  wire logic                           lock_req,
    input  wire logic                           stretch_req,
    input  wire logic                           drain_req,
    // user response side
    input  wire logic                           resp_go,
    input  wire logic [hbs_pkg::RESP_W-1:0]     resp_code,
    input  wire logic                           resp_defer,
    // user send side
    input  wire logic                           send_start,
    input  wire logic                           wr_valid,
    input  wire logic [hbs_pkg::DATA_W-1:0]     wr_data,
    input  wire logic                           wr_last,
    output logic                                wr_ready,
    // user receive side
    input  wire logic                           rx_accept,
    output logic                                rx_valid,
    output logic      [hbs_pkg::DATA_W-1:0]     rx_data,
    output logic      [hbs_pkg::BE_W-1:0]       rx_lanes,
    output logic                                rx_ecc_err,
    output logic                                req_parity_err,
    output logic                                resp_parity_err
);
    import hbs_pkg::*;

    hbs_ecc_if ecc ();
    hbs_ecc u_ecc (.ecc(ecc.codec));

    // ------------------------------------------------------------
    // bus decode in asserted sense
    // ------------------------------------------------------------
    logic             ads_seen;
    logic [REQ_W-1:0] req_seen;
    logic [BE_W-1:0]  be_seen;
    logic             rp_seen;
    logic             ads_d_r;
    logic [REQ_W-1:0] cmd_a_r;
    logic [BE_W-1:0]  lanes_r;
    logic             smi_hit;
    logic             req_clk2;
    assign ads_seen = ~addr_strobe_n_in;
    assign req_seen = ~req_type_n_in;
    assign be_seen  = ~byte_en_n_in;
    assign rp_seen  = ~cmd_parity_n_in;
    assign req_clk2 = ads_d_r;
    assign smi_hit  = req_clk2 && (cmd_a_r == CMD_SPECIAL) && (be_seen == MSG_SMI_ACK);

    // command latched with the strobe, lanes chosen in the second clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ads_d_r <= 1'b0;
            cmd_a_r <= '0;
            lanes_r <= BE_ALL;
        end else begin
            ads_d_r <= ads_seen;
            if (ads_seen) cmd_a_r <= req_seen;
            if (req_clk2) begin
                // line length opens every lane, otherwise the enables decide
                lanes_r <= (req_seen[LEN_LSB +: 2] == LEN_LINE) ? BE_ALL : be_seen;
            end
        end
    end

    // ------------------------------------------------------------
    // parity checks on observed request and response
    // ------------------------------------------------------------
    logic resp_active;
    logic req_par_bad;
    logic resp_par_bad;
    logic [RESP_W-1:0] resp_seen;
    assign resp_seen    = ~response_code_n_in;
    assign resp_active  = resp_seen != RESP_IDLE;
    // ads is part of the coverage, so it counts as 0 in the second clock
    assign req_par_bad  = (ads_seen || req_clk2) && ^{req_seen, ads_seen, rp_seen};
    assign resp_par_bad = resp_active && ^{resp_seen, ~resp_parity_n_in};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_parity_err  <= 1'b0;
            resp_parity_err <= 1'b0;
        end else begin
            req_parity_err  <= req_par_bad;
            resp_parity_err <= resp_par_bad;
        end
    end

    // ------------------------------------------------------------
    // request issue: strobe in first clock, length in second
    // ------------------------------------------------------------
    logic             rq_ph1_r;
    logic             rq_ph2_r;
    logic [REQ_W-1:0] rq_lines_r;
    logic [REQ_W-1:0] rq_len_r;
    logic             rq_start;
    assign rq_start = req_go && !rq_ph1_r && !rq_ph2_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rq_ph1_r   <= 1'b0;
            rq_ph2_r   <= 1'b0;
            rq_lines_r <= '0;
            rq_len_r   <= '0;
        end else begin
            rq_ph1_r <= rq_start;
            rq_ph2_r <= rq_ph1_r;
            if (rq_start) begin
                rq_lines_r <= req_cmd;
                rq_len_r   <= req_len;
            end else if (rq_ph1_r) begin
                rq_lines_r <= rq_len_r;
            end
        end
    end

    assign addr_strobe_n_out = ~rq_ph1_r;
    assign addr_strobe_oe    = rq_ph1_r || rq_ph2_r;
    assign req_type_n_out    = ~rq_lines_r;
    assign req_type_oe       = addr_strobe_oe;
    assign cmd_parity_n_out  = ~(^{rq_lines_r, rq_ph1_r});
    assign cmd_parity_oe     = addr_strobe_oe;

    // ------------------------------------------------------------
    // data owner: registered beats, hold until the last beat
    // ------------------------------------------------------------
    hbs_dp_type        dp_r;
    hbs_dp_type        dp_nxt;
    logic              beat;
    logic              own_r;
    logic              valid_r;
    logic              hold_r;
    logic [DATA_W-1:0] tx_r;
    logic [ECC_W-1:0]  txc_r;
    assign wr_ready = (dp_r == HBS_DP_SEND);
    assign beat     = wr_ready && wr_valid;

    always_comb begin
        case (dp_r)
            HBS_DP_IDLE: dp_nxt = send_start ? HBS_DP_SEND : HBS_DP_IDLE;
            HBS_DP_SEND: dp_nxt = (beat && wr_last) ? HBS_DP_IDLE : HBS_DP_SEND;
            default:     dp_nxt = HBS_DP_IDLE;
        endcase
    end

    assign ecc.tx_data = wr_data;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dp_r    <= HBS_DP_IDLE;
            own_r   <= 1'b0;
            valid_r <= 1'b0;
            hold_r  <= 1'b0;
            tx_r    <= '0;
            txc_r   <= '0;
        end else begin
            dp_r    <= dp_nxt;
            own_r   <= wr_ready;
            valid_r <= beat;
            hold_r  <= wr_ready && !(beat && wr_last);
            if (beat) begin
                tx_r  <= wr_data;
                txc_r <= ecc.tx_check;
            end
        end
    end

    assign data_n_out       = ~tx_r;
    assign data_ecc_n_out   = ~txc_r;
    assign data_oe          = own_r;
    assign data_valid_n_out = ~valid_r;
    assign data_hold_n_out  = ~hold_r;

    // ------------------------------------------------------------
    // data receiver: target ready, capture, check
    // ------------------------------------------------------------
    logic take;
    assign take            = !own_r && !data_valid_n_in;
    assign ecc.rx_data     = ~data_n_in;
    assign ecc.rx_check    = ~data_ecc_n_in;
    assign target_ready_oe = !own_r;
    assign target_ready_n_out = ~(rx_accept && !own_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_valid   <= 1'b0;
            rx_data    <= '0;
            rx_lanes   <= '0;
            rx_ecc_err <= 1'b0;
        end else begin
            rx_valid   <= take;
            rx_ecc_err <= take && ecc.rx_bad;
            if (take) begin
                rx_data  <= ecc.rx_data;
                rx_lanes <= lanes_r;
            end
        end
    end

    // ------------------------------------------------------------
    // response, deferral, snoop stretch, lock, sideband
    // ------------------------------------------------------------
    logic [RESP_W-1:0] rs_r;
    logic rs_on_r;
    logic defer_r;
    logic stretch_r;
    logic lock_r;
    logic drain_r;
    logic smi_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rs_r      <= RESP_IDLE;
            rs_on_r   <= 1'b0;
            defer_r   <= 1'b0;
            stretch_r <= 1'b0;
            lock_r    <= 1'b0;
            drain_r   <= FLUSH_RST;
            smi_r     <= SMI_RST;
        end else begin
            rs_on_r   <= resp_go;
            rs_r      <= resp_go ? resp_code : RESP_IDLE;
            defer_r   <= resp_go && resp_defer;
            stretch_r <= stretch_req;
            lock_r    <= lock_req;
            drain_r   <= drain_req && COMPAT_BRIDGE;
            // qualifier decides set or clear on the same special cycle
            if (smi_hit && COMPAT_BRIDGE) smi_r <= !sysmgmt_space_n_in;
        end
    end

    assign response_code_n_out  = ~rs_r;
    assign resp_parity_n_out    = ~(^rs_r);
    assign resp_oe              = rs_on_r;
    assign defer_n_out          = ~defer_r;
    assign defer_oe             = rs_on_r;
    // one flop feeds both lines so they can never split
    assign snoop_hit_n_out      = ~stretch_r;
    assign snoop_modified_n_out = ~stretch_r;
    assign snoop_oe             = stretch_r;
    assign lock_n_out           = ~lock_r;
    assign lock_oe              = lock_r;
    assign cache_drain_n        = ~drain_r;
    assign sysmgmt_ack_n        = ~smi_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    strobe_once_a: assert property (!addr_strobe_n_out |=> addr_strobe_n_out && req_type_oe)
        else $error("strobe longer than one clock");
    req_phase2_a: assert property (rq_ph1_r |=> (~req_type_n_out) == $past(rq_len_r))
        else $error("second request clock lacks length");
    req_par_a: assert property (req_type_oe |-> ^{~req_type_n_out, ~addr_strobe_n_out, ~cmd_parity_n_out} == 1'b0)
        else $error("request parity odd");
    hold_single_a: assert property (beat && wr_last && !$past(beat) && $past(dp_r) == HBS_DP_IDLE |=> data_hold_n_out)
        else $error("hold on single clock transfer");
    valid_beat_a: assert property (beat |=> !data_valid_n_out && data_oe ##1 (data_valid_n_out || $past(beat)))
        else $error("data valid not tied to beat");
    ecc_tx_a: assert property (beat |=> (~data_ecc_n_out) == $past(ecc.tx_check))
        else $error("check lanes do not follow data");
    snoop_pair_a: assert property (snoop_hit_n_out == snoop_modified_n_out)
        else $error("snoop lines split");
    stretch_both_a: assert property (stretch_req |=> !snoop_hit_n_out && !snoop_modified_n_out)
        else $error("stretch not driven");
    resp_par_a: assert property (resp_oe |-> ^{~response_code_n_out, ~resp_parity_n_out} == 1'b0)
        else $error("response parity odd");
    defer_a: assert property (resp_go && resp_defer |=> !defer_n_out && resp_oe)
        else $error("defer missing");
    smi_set_a: assert property (smi_hit && !sysmgmt_space_n_in && COMPAT_BRIDGE |=> !sysmgmt_ack_n)
        else $error("management ack not set");
    smi_hold_a: assert property (!sysmgmt_ack_n && !smi_hit |=> !sysmgmt_ack_n)
        else $error("management ack dropped early");
    aux_quiet_a: assert property (!COMPAT_BRIDGE |-> cache_drain_n && sysmgmt_ack_n)
        else $error("auxiliary bridge drives sideband");
    drain_a: assert property (drain_req && COMPAT_BRIDGE |=> !cache_drain_n)
        else $error("cache drain missing");
    lock_hold_a: assert property (lock_req [*2] |-> !lock_n_out)
        else $error("lock dropped mid sequence");
    tready_a: assert property (rx_accept && !own_r |-> !target_ready_n_out && target_ready_oe)
        else $error("target ready missing");
    lanes_a: assert property (take |=> rx_lanes == $past(lanes_r))
        else $error("lane mask wrong");

    burst_c: cover property (beat ##1 beat ##1 beat && wr_last);
    smi_c:   cover property (!sysmgmt_ack_n ##[1:50] sysmgmt_ack_n);
    rx_c:    cover property (take ##1 rx_valid);
    req_c:   cover property (rq_ph1_r ##1 rq_ph2_r);
endmodule // hbs_host_agent
`default_nettype wire

// ---- verilog/hbs_pkg.sv ----
package hbs_pkg;
    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int DATA_W = 64;
    localparam int ECC_W  = 8;
    localparam int BE_W   = 8;
    localparam int REQ_W  = 5;
    localparam int RESP_W = 3;

    // ------------------------------------------------------------
    // request and response encodings (asserted-sense values)
    // ------------------------------------------------------------
    localparam logic [REQ_W-1:0]  CMD_SPECIAL  = 5'h08;
    localparam logic [BE_W-1:0]   MSG_SMI_ACK  = 8'h04;
    localparam int                LEN_LSB      = 0;
    localparam logic [1:0]        LEN_LINE     = 2'h2;
    localparam logic [BE_W-1:0]   BE_ALL       = 8'hFF;
    localparam logic [RESP_W-1:0] RESP_IDLE    = 3'h0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic SMI_RST   = 1'b0;
    localparam logic FLUSH_RST = 1'b0;

    // ------------------------------------------------------------
    // check lane k covers data bits whose low or high octal digit is k
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] hbs_ecc_mask(input int k);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < DATA_W; i++) begin
            m[i] = ((i % 8) == k) || ((i / 8) == k);
        end
        return m;
    endfunction

    typedef enum logic [0:0] {
        HBS_DP_IDLE,
        HBS_DP_SEND
    } hbs_dp_type;
endpackage

// ---- verilog/hbs_ecc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// check lane traffic between the agent and its codec
interface hbs_ecc_if;
    logic [hbs_pkg::DATA_W-1:0] tx_data;
    logic [hbs_pkg::ECC_W-1:0]  tx_check;
    logic [hbs_pkg::DATA_W-1:0] rx_data;
    logic [hbs_pkg::ECC_W-1:0]  rx_check;
    logic                       rx_bad;
    modport agent (output tx_data, input tx_check, output rx_data, output rx_check, input rx_bad);
    modport codec (input tx_data, output tx_check, input rx_data, input rx_check, output rx_bad);
endinterface
`default_nettype wire

// ---- verilog/hbs_ecc.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbs_ecc (
    hbs_ecc_if.codec ecc
);
    import hbs_pkg::*;

    logic [ECC_W-1:0] rx_calc;

    // ------------------------------------------------------------
    // one xor tree per check lane, shared mask for send and check
    // ------------------------------------------------------------
    for (genvar k = 0; k < ECC_W; k++) begin : g_lane
        localparam logic [DATA_W-1:0] MASK = hbs_ecc_mask(k);
        assign ecc.tx_check[k] = ^(ecc.tx_data & MASK);
        assign rx_calc[k]      = ^(ecc.rx_data & MASK);
    end

    // any syndrome bit set flags the word
    assign ecc.rx_bad = |(rx_calc ^ ecc.rx_check);
endmodule // hbs_ecc
`default_nettype wire

// ---- test/hbs_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// processor side of the host bus
// ------------------------------------------------------------
module hbs_bus_model (
    // clock
    input  wire logic        clk_sys,
    // request lines, low active
    output logic             addr_strobe_n_in,
    output logic [4:0]       req_type_n_in,
    output logic             cmd_parity_n_in,
    output logic [7:0]       byte_en_n_in,
    output logic             sysmgmt_space_n_in,
    // data lines, low active
    output logic [63:0]      data_n_in,
    output logic [7:0]       data_ecc_n_in,
    output logic             data_valid_n_in
);
    // lane k takes bits whose low or high octal digit is k
    function automatic logic [7:0] ecc(input logic [63:0] d);
        ecc = '0;
        for (int i = 0; i < 64; i++) begin
            ecc[i%8] ^= d[i];
            if (i / 8 != i % 8) begin
                ecc[i/8] ^= d[i];
            end
        end
    endfunction
    // released lines sit at termination level, which reads negated
    task automatic idle;
        {addr_strobe_n_in, req_type_n_in, cmd_parity_n_in, byte_en_n_in} = '1;
        {sysmgmt_space_n_in, data_n_in, data_ecc_n_in, data_valid_n_in} = '1;
    endtask
    initial idle();
    // two-clock request: command with strobe, then length and enables
    task automatic req(input logic [4:0] cmd, len, input logic [7:0] be, input logic sp);
        @(posedge clk_sys);
        #1;
        addr_strobe_n_in = 1'h0;
        req_type_n_in = ~cmd;
        cmd_parity_n_in = ~(^cmd ^ 1'h1);
        @(posedge clk_sys);
        #1;
        addr_strobe_n_in = 1'h1;
        req_type_n_in = ~len;
        cmd_parity_n_in = ~(^len);
        byte_en_n_in = ~be;
        sysmgmt_space_n_in = sp;
        @(posedge clk_sys);
        #1;
        idle();
    endtask
    // one data clock; bad spoils lane 0 to provoke the checker
    task automatic beat(input logic [63:0] d, input logic bad);
        @(posedge clk_sys);
        #1;
        data_valid_n_in = 1'h0;
        data_n_in = ~d;
        data_ecc_n_in = ~(ecc(d) ^ {7'h00, bad});
        @(posedge clk_sys);
        #1;
        idle();
    endtask
endmodule // hbs_bus_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hbs_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed lines
    // ------------------------------------------------------------
    logic clk_sys = 1'h0, rst = 1'h1, req_go = 1'h0, resp_go = 1'h0, send_start = 1'h0;
    logic lock_req = 1'h0, stretch_req = 1'h0, drain_req = 1'h0, wr_valid = 1'h0, wr_last = 1'h0;
    logic resp_defer = 1'h0, rx_accept = 1'h1;
    logic [4:0] req_cmd = '0, req_len = '0;
    logic [2:0] resp_code = '0, response_code_n_out;
    logic [63:0] wr_data = '0, data_n_out, rx_data;
    wire logic addr_strobe_n_in, cmd_parity_n_in, sysmgmt_space_n_in, data_valid_n_in;
    wire logic [4:0] req_type_n_in;
    wire logic [7:0] byte_en_n_in, data_ecc_n_in;
    wire logic [63:0] data_n_in;
    logic addr_strobe_n_out, cmd_parity_n_out, data_oe, data_valid_n_out, data_hold_n_out;
    logic target_ready_oe, resp_oe, resp_parity_n_out, snoop_hit_n_out, snoop_modified_n_out;
    logic lock_n_out, cache_drain_n, sysmgmt_ack_n, wr_ready, rx_valid, rx_ecc_err;
    logic defer_n_out, target_ready_n_out, req_parity_err, resp_parity_err;
    logic [4:0] req_type_n_out;
    logic [7:0] data_ecc_n_out, rx_lanes;
    int n_fail = 0, n_tests = 0;
    hbs_host_agent hbs_host_agent_inst (.clk_sys, .rst, .addr_strobe_n_in, .addr_strobe_n_out,
        .addr_strobe_oe(), .req_type_n_in, .req_type_n_out, .req_type_oe(), .cmd_parity_n_in,
        .cmd_parity_n_out, .cmd_parity_oe(), .byte_en_n_in, .sysmgmt_space_n_in, .data_n_in,
        .data_n_out, .data_ecc_n_in, .data_ecc_n_out, .data_oe, .data_valid_n_in,
        .data_valid_n_out, .data_hold_n_out, .target_ready_n_in(1'h1), .target_ready_n_out,
        .target_ready_oe, .defer_n_out, .defer_oe(), .response_code_n_in(response_code_n_out),
        .response_code_n_out, .resp_parity_n_in(resp_parity_n_out), .resp_parity_n_out, .resp_oe,
        .snoop_hit_n_out, .snoop_modified_n_out, .snoop_oe(), .lock_n_out, .lock_oe(),
        .cache_drain_n, .sysmgmt_ack_n, .req_go, .req_cmd, .req_len, .lock_req, .stretch_req,
        .drain_req, .resp_go, .resp_code, .resp_defer, .send_start, .wr_valid, .wr_data,
        .wr_last, .wr_ready, .rx_accept, .rx_valid, .rx_data, .rx_lanes, .rx_ecc_err,
        .req_parity_err, .resp_parity_err);
    hbs_bus_model hbs_bus_model_inst (.clk_sys, .addr_strobe_n_in, .req_type_n_in,
        .cmd_parity_n_in, .byte_en_n_in, .sysmgmt_space_n_in, .data_n_in, .data_ecc_n_in,
        .data_valid_n_in);
    initial forever #12.5 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_request(input logic [4:0] cmd, input logic [4:0] len);
        {req_cmd, req_len, req_go} = {cmd, len, 1'h1};
        tick();
        req_go = 1'h0;
        chk(addr_strobe_n_out, 1'h0);
        chk(req_type_n_out, 5'(~cmd));
        chk(cmd_parity_n_out, !(^cmd ^ 1'h1));
        tick();
        chk(addr_strobe_n_out, 1'h1);
        chk(req_type_n_out, 5'(~len));
        chk(cmd_parity_n_out, !(^len));
        tick();
    endtask
    task automatic t_smi(input logic [7:0] be, input logic sp, input logic exp);
        hbs_bus_model_inst.req(CMD_SPECIAL, 5'h00, be, sp);
        // flag still shows the verdict on the second request clock
        chk(req_parity_err, 1'h0);
        tick();
        chk(sysmgmt_ack_n, exp);
    endtask
    task automatic t_rx(input logic [4:0] len, input logic [7:0] be, lanes, input logic bad);
        hbs_bus_model_inst.req(5'h00, len, be, 1'h1);
        hbs_bus_model_inst.beat(64'h0123_4567_89AB_CDEF, bad);
        chk(rx_valid, 1'h1);
        chk(rx_data, 64'h0123_4567_89AB_CDEF);
        chk(rx_lanes, lanes);
        chk(rx_ecc_err, bad);
        tick();
        chk(rx_valid, 1'h0);
    endtask
    task automatic t_resp;
        for (int c = 0; c < 8; c++) begin
            {resp_code, resp_defer, resp_go} = {3'(c), c[0], 1'h1};
            tick();
            resp_go = 1'h0;
            chk(resp_oe, 1'h1);
            chk(defer_n_out, !c[0]);
            chk(response_code_n_out, 3'(~resp_code));
            chk(resp_parity_n_out, !(^resp_code));
            tick();
            chk(resp_oe, 1'h0);
            chk(resp_parity_err, 1'h0);
        end
    endtask
    task automatic t_levels(input logic v);
        {lock_req, stretch_req, drain_req, rx_accept} = {4{v}};
        tick();
        chk(snoop_hit_n_out, !v);
        chk(snoop_modified_n_out, !v);
        chk(lock_n_out, !v);
        chk(cache_drain_n, !v);
        chk(target_ready_n_out, !v);
    endtask
    // hold stays asserted on every beat but the last one
    task automatic t_send(input int beats);
        int n;
        logic [63:0] d;
        send_start = 1'h1;
        tick();
        send_start = 1'h0;
        for (n = 0; n < 8 && wr_ready !== 1'h1; n++) tick();
        chk(n < 8, 1'h1);
        if (n >= 8) results();
        for (int b = 1; b <= beats; b++) begin
            d = 64'hFFFF_0000_1234_5678 ^ 64'(b * 165);
            {wr_valid, wr_last, wr_data} = {1'h1, b == beats, d};
            tick();
            chk(data_oe, 1'h1);
            chk(data_valid_n_out, 1'h0);
            chk(data_hold_n_out, b == beats);
            chk(data_n_out, ~d);
            chk(data_ecc_n_out, 8'(~hbs_bus_model_inst.ecc(d)));
        end
        wr_valid = 1'h0;
        tick();
        chk(data_oe, 1'h0);
        chk(data_valid_n_out, 1'h1);
        chk(target_ready_oe, 1'h1);
    endtask
    initial begin
        repeat (10) tick();
        chk({cache_drain_n, sysmgmt_ack_n, data_oe, target_ready_oe}, 4'hD);
        rst = 1'h0;
        tick();
        t_request(5'h15, 5'h0A);
        t_request(5'h03, 5'h1C);
        t_smi(8'h02, 1'h0, 1'h1);
        t_smi(MSG_SMI_ACK, 1'h0, 1'h0);
        t_smi(8'h02, 1'h1, 1'h0);
        t_smi(MSG_SMI_ACK, 1'h1, 1'h1);
        t_rx(5'h02, 8'h0F, BE_ALL, 1'h0);
        t_rx(5'h00, 8'h0F, 8'h0F, 1'h1);
        t_resp();
        t_levels(1'h1);
        t_levels(1'h0);
        t_send(2);
        t_send(1);
        results();
    end
endmodule // tb
`default_nettype wire
